// ---- rtl/dac_port_consts.svh ----
`ifndef DAC_PORT_CONSTS_SVH
`define DAC_PORT_CONSTS_SVH

// Frame lengths in serial clock falling edges
`define FRAME_BITS_SHORT 6'd24
`define FRAME_BITS_LONG 6'd32
`define FRAME_CNT_MAX 6'h3f
`define FRAME_CNT_FIRST 6'h01

// Payload layout (24 bits, long frames append an 8-bit check byte)
`define PAY_ADDR_HI 22
`define PAY_ADDR_LO 21
`define PAY_CHAN_HI 20
`define PAY_CHAN_LO 19
`define PAY_CMD_HI 18
`define PAY_CMD_LO 16
`define PAY_DATA_HI 15
`define PAY_DATA_LO 0
`define CHECK_HI 7
`define CHECK_LO 0

// Command field encodings
`define CMD_WRITE_DATA 3'h0
`define CMD_WRITE_CLEAR_CODE 3'h1
`define CMD_WRITE_CLEAR_EN 3'h2
`define CMD_READBACK 3'h3
`define CMD_NOP 3'h4

// Readback source select, taken from the data field
`define RB_SRC_INPUT 2'h0
`define RB_SRC_OUTPUT 2'h1
`define RB_SRC_CLEAR_CODE 2'h2
`define RB_SRC_CLEAR_EN 2'h3
`define RB_PAD 4'h0

// Check byte: x^8 + x^2 + x + 1, seed zero
`define CHECK_POLY 8'h07
`define CHECK_SEED 8'h00

// Reset values
`define CODE_RESET 16'h0000
`define CLEAR_EN_RESET 1'b0
`define RB_WORD_RESET 24'h000000

// Pin synchroniser slots and their idle levels
`define PIN_SYNC_N 0
`define PIN_LOAD_N 1
`define PIN_CLEAR 2
`define PIN_RESET_N 3
`define PIN_LONG 4
`define PIN_ADDR0 5
`define PIN_ADDR1 6
`define PIN_COUNT 7
`define PIN_IDLE 7'b000_1011

`endif

// ---- rtl/dac_port_pkg.sv ----
package dac_port_pkg;

  typedef logic [15:0] code_t;
  typedef logic [23:0] payload_t;

  typedef enum {
    CMD_E_WRITE_DATA,
    CMD_E_WRITE_CLEAR_CODE,
    CMD_E_WRITE_CLEAR_EN,
    CMD_E_READBACK,
    CMD_E_NONE
  } cmd_e;

endpackage : dac_port_pkg

// ---- rtl/dac_serial_load_clear_port.sv ----
`timescale 1ns/1ps
`include "dac_port_consts.svh"

module dac_serial_load_clear_port
  import dac_port_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int CODE_W = 16
)
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Serial link
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_in,
  output logic serial_out,
  // Control pins
  input wire logic load_outputs_n,
  input wire logic clear,
  input wire logic reset_n,
  input wire logic long_frame_en,
  input wire logic board_addr_bit0,
  input wire logic board_addr_bit1,
  // Channel output codes and status
  output logic [CHANNELS-1:0][CODE_W-1:0] dac_codes,
  output logic check_error
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic cmd_e decode_cmd(input logic [2:0] field);
    cmd_e c;
    c = CMD_E_NONE;
    unique case (field)
      `CMD_WRITE_DATA: c = CMD_E_WRITE_DATA;
      `CMD_WRITE_CLEAR_CODE: c = CMD_E_WRITE_CLEAR_CODE;
      `CMD_WRITE_CLEAR_EN: c = CMD_E_WRITE_CLEAR_EN;
      `CMD_READBACK: c = CMD_E_READBACK;
      default: c = CMD_E_NONE;
    endcase
    return c;
  endfunction : decode_cmd

  function automatic logic [7:0] check_byte(input payload_t p);
    logic [7:0] crc;
    logic fb;
    crc = `CHECK_SEED;
    for (int i = 23; i >= 0; i--)
    begin
      fb = crc[7] ^ p[i];
      crc = {crc[6:0], 1'b0};
      if (fb)
      begin
        crc = crc ^ `CHECK_POLY;
      end
    end
    return crc;
  endfunction : check_byte

  // ------------------------------------------------------------------
  // Link domain: input shift on falling serial clock
  // ------------------------------------------------------------------
  // The serial clock may run faster than ref_clk, so bits are taken
  // on the link clock itself and handed over whole at frame end.
  logic fresh_q;
  logic [31:0] in_shift_q;
  logic [5:0] bit_cnt_q;

  // Marks the first falling edge of a frame; preset while select is high
  always_ff @(negedge sclk or posedge frame_sync_n)
  begin
    if (frame_sync_n)
    begin
      fresh_q <= 1'b1;
    end
    else
    begin
      fresh_q <= 1'b0;
    end
  end

  // Word and count hold after the frame, while the clock stands still
  always_ff @(negedge sclk)
  begin
    if (!frame_sync_n)
    begin
      if (fresh_q)
      begin
        in_shift_q <= {31'h0, serial_in};
        bit_cnt_q <= `FRAME_CNT_FIRST;
      end
      else
      begin
        in_shift_q <= {in_shift_q[30:0], serial_in};
        if (bit_cnt_q != `FRAME_CNT_MAX)
        begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Link domain: readback shift on rising serial clock
  // ------------------------------------------------------------------
  logic out_first_q;
  logic [23:0] out_shift_q;
  logic [23:0] rb_word_q;

  always_ff @(posedge sclk or posedge frame_sync_n)
  begin
    if (frame_sync_n)
    begin
      out_first_q <= 1'b1;
    end
    else
    begin
      out_first_q <= 1'b0;
    end
  end

  // Assumes the clock idles high so the first edge after select is a fall
  always_ff @(posedge sclk)
  begin
    if (out_first_q)
    begin
      out_shift_q <= {rb_word_q[22:0], 1'b0};
    end
    else
    begin
      out_shift_q <= {out_shift_q[22:0], 1'b0};
    end
  end

  // First bit comes straight from the held word, later bits from the shifter
  assign serial_out = out_first_q ? rb_word_q[23] : out_shift_q[23];

  // ------------------------------------------------------------------
  // Pin synchronisers into ref_clk
  // ------------------------------------------------------------------
  logic [`PIN_COUNT-1:0] pin_raw;
  logic [`PIN_COUNT-1:0] pin_s1_q;
  logic [`PIN_COUNT-1:0] pin_s2_q;
  logic [`PIN_COUNT-1:0] pin_s3_q;
  logic [`PIN_COUNT-1:0] pin_q;

  assign pin_raw = {board_addr_bit1, board_addr_bit0, long_frame_en, reset_n, clear,
                    load_outputs_n, frame_sync_n};

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++)
    begin : g_pin
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          pin_s1_q[gi] <= 1'(`PIN_IDLE >> gi);
          pin_s2_q[gi] <= 1'(`PIN_IDLE >> gi);
          pin_s3_q[gi] <= 1'(`PIN_IDLE >> gi);
          pin_q[gi] <= 1'(`PIN_IDLE >> gi);
        end
        else
        begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          // A change counts once the last two stages agree
          if (pin_s2_q[gi] == pin_s3_q[gi])
          begin
            pin_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Edge detection and frame decode
  // ------------------------------------------------------------------
  logic pin_prev_sync_q;
  logic pin_prev_load_q;
  logic pin_prev_clear_q;
  logic hw_rst;
  logic frame_end;
  logic load_fall;
  logic clear_rise;
  logic clear_active;

  assign hw_rst = sys_rst || !pin_q[`PIN_RESET_N];

  always_ff @(posedge ref_clk)
  begin
    if (hw_rst)
    begin
      pin_prev_sync_q <= pin_q[`PIN_SYNC_N];
      pin_prev_load_q <= pin_q[`PIN_LOAD_N];
      pin_prev_clear_q <= pin_q[`PIN_CLEAR];
    end
    else
    begin
      pin_prev_sync_q <= pin_q[`PIN_SYNC_N];
      pin_prev_load_q <= pin_q[`PIN_LOAD_N];
      pin_prev_clear_q <= pin_q[`PIN_CLEAR];
    end
  end

  assign frame_end = pin_q[`PIN_SYNC_N] && !pin_prev_sync_q;
  assign load_fall = !pin_q[`PIN_LOAD_N] && pin_prev_load_q;
  assign clear_rise = pin_q[`PIN_CLEAR] && !pin_prev_clear_q;
  assign clear_active = pin_q[`PIN_CLEAR];

  logic long_mode;
  logic len_ok;
  logic check_ok;
  logic addr_ok;
  logic frame_ok;
  payload_t payload;
  cmd_e cmd;
  logic [1:0] chan;
  code_t data;

  // Link word is stable here: select has been high for four ref clocks
  assign long_mode = pin_q[`PIN_LONG];
  assign len_ok = long_mode ? (bit_cnt_q == `FRAME_BITS_LONG)
                            : (bit_cnt_q == `FRAME_BITS_SHORT);
  assign payload = long_mode ? in_shift_q[31:8] : in_shift_q[23:0];
  assign check_ok = !long_mode || (check_byte(payload) == in_shift_q[`CHECK_HI:`CHECK_LO]);
  assign addr_ok = payload[`PAY_ADDR_HI:`PAY_ADDR_LO] ==
                   {pin_q[`PIN_ADDR1], pin_q[`PIN_ADDR0]};
  assign frame_ok = frame_end && len_ok && check_ok && addr_ok;
  assign cmd = decode_cmd(payload[`PAY_CMD_HI:`PAY_CMD_LO]);
  assign chan = payload[`PAY_CHAN_HI:`PAY_CHAN_LO];
  assign data = payload[`PAY_DATA_HI:`PAY_DATA_LO];

  // Flag a bad check byte on a complete, addressed long frame
  always_ff @(posedge ref_clk)
  begin
    if (hw_rst)
    begin
      check_error <= 1'b0;
    end
    else if (frame_end && len_ok && addr_ok)
    begin
      check_error <= !check_ok;
    end
  end

  // ------------------------------------------------------------------
  // Channel registers
  // ------------------------------------------------------------------
  code_t input_reg_q [CHANNELS];
  code_t output_reg_q [CHANNELS];
  code_t clear_code_q [CHANNELS];
  logic [CHANNELS-1:0] clear_en_q;

  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_chan
      logic hit;
      assign hit = frame_ok && (chan == 2'(gi));

      always_ff @(posedge ref_clk)
      begin
        if (hw_rst)
        begin
          input_reg_q[gi] <= `CODE_RESET;
        end
        else if (hit && cmd == CMD_E_WRITE_DATA)
        begin
          input_reg_q[gi] <= data;
        end
      end

      always_ff @(posedge ref_clk)
      begin
        if (hw_rst)
        begin
          clear_code_q[gi] <= `CODE_RESET;
          clear_en_q[gi] <= `CLEAR_EN_RESET;
        end
        else
        begin
          if (hit && cmd == CMD_E_WRITE_CLEAR_CODE)
          begin
            clear_code_q[gi] <= data;
          end
          if (hit && cmd == CMD_E_WRITE_CLEAR_EN)
          begin
            clear_en_q[gi] <= data[0];
          end
        end
      end

      // Clear wins over a load landing in the same cycle
      always_ff @(posedge ref_clk)
      begin
        if (hw_rst)
        begin
          output_reg_q[gi] <= `CODE_RESET;
        end
        else if (clear_rise)
        begin
          if (clear_en_q[gi])
          begin
            output_reg_q[gi] <= clear_code_q[gi];
          end
        end
        else if (!clear_active)
        begin
          if (load_fall)
          begin
            output_reg_q[gi] <= input_reg_q[gi];
          end
          else if (hit && cmd == CMD_E_WRITE_DATA && !pin_q[`PIN_LOAD_N])
          begin
            output_reg_q[gi] <= data;
          end
        end
      end

      assign dac_codes[gi] = output_reg_q[gi];
    end
  endgenerate

  // ------------------------------------------------------------------
  // Readback word, shifted out during the next frame
  // ------------------------------------------------------------------
  code_t rb_data;

  always_comb
  begin
    rb_data = `CODE_RESET;
    unique case (data[1:0])
      `RB_SRC_INPUT: rb_data = input_reg_q[chan];
      `RB_SRC_OUTPUT: rb_data = output_reg_q[chan];
      `RB_SRC_CLEAR_CODE: rb_data = clear_code_q[chan];
      `RB_SRC_CLEAR_EN: rb_data = {15'h0000, clear_en_q[chan]};
    endcase
  end

  // Held word is only changed between frames, so the link side reads it static
  always_ff @(posedge ref_clk)
  begin
    if (hw_rst)
    begin
      rb_word_q <= `RB_WORD_RESET;
    end
    else if (frame_ok && cmd == CMD_E_READBACK)
    begin
      rb_word_q <= {`RB_PAD, chan, data[1:0], rb_data};
    end
  end

endmodule : dac_serial_load_clear_port

// ---- verification/port_checks_asserts.sv ----
`timescale 1ns/1ps
module port_checks
  import dac_port_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int CODE_W = 16
)
(
  // Clock, reset and link
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_in,
  input wire logic serial_out,
  // Pins
  input wire logic load_outputs_n,
  input wire logic clear,
  input wire logic reset_n,
  input wire logic long_frame_en,
  input wire logic board_addr_bit0,
  input wire logic board_addr_bit1,
  // Results
  input wire logic [CHANNELS-1:0][CODE_W-1:0] dac_codes,
  input wire logic check_error
);
  // ---
  // Cycles since each kind of cause
  // ---
  logic [3:0] ev_q, frm_q, ld_q, clr_q;
  logic so_q, fell_q;
  logic kill;
  assign kill = sys_rst || !reset_n;
  always_ff @(posedge ref_clk)
  begin
    ev_q <= (kill || $rose(frame_sync_n) || $fell(load_outputs_n) || $rose(clear)) ? 4'h0 : ev_q + {3'h0, ~&ev_q};
    frm_q <= (kill || $rose(frame_sync_n)) ? 4'h0 : frm_q + {3'h0, ~&frm_q};
    ld_q <= (kill || !load_outputs_n || $rose(clear)) ? 4'h0 : ld_q + {3'h0, ~&ld_q};
    clr_q <= (kill || !clear) ? 4'h0 : clr_q + {3'h0, ~&clr_q};
  end
  // Async clear so a new frame never compares against the previous one
  always_ff @(negedge sclk or posedge frame_sync_n)
  begin
    if (frame_sync_n)
      fell_q <= 1'b0;
    else
      fell_q <= 1'b1;
  end
  always_ff @(negedge sclk)
  begin
    so_q <= serial_out;
  end
  // ---
  // Properties
  // ---
  property p_codes_quiet;
    @(posedge ref_clk) disable iff (sys_rst) ev_q >= 4'd12 |-> $stable(dac_codes);
  endproperty
  a_codes_quiet: assert property (p_codes_quiet) else $error("outputs moved without a cause");
  property p_err_quiet;
    @(posedge ref_clk) disable iff (sys_rst) frm_q >= 4'd12 |-> $stable(check_error);
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("check flag moved outside frame end");
  property p_load_high;
    @(posedge ref_clk) disable iff (sys_rst) ld_q >= 4'd12 |-> $stable(dac_codes);
  endproperty
  a_load_high: assert property (p_load_high) else $error("outputs moved while load high");
  property p_clear_blocks;
    @(posedge ref_clk) disable iff (sys_rst) clr_q >= 4'd12 |-> $stable(dac_codes);
  endproperty
  a_clear_blocks: assert property (p_clear_blocks) else $error("output written while clear high");
  property p_hw_reset;
    @(posedge ref_clk) disable iff (sys_rst) !reset_n [*8] |-> dac_codes == '0 && !check_error;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("reset pin did not clear outputs");
  property p_sys_reset;
    @(posedge ref_clk) disable iff (sys_rst) $fell(sys_rst) |-> dac_codes == '0 && !check_error;
  endproperty
  a_sys_reset: assert property (p_sys_reset) else $error("outputs not zero after reset");
  property p_err_long;
    @(posedge ref_clk) disable iff (sys_rst) $rose(check_error) |-> long_frame_en;
  endproperty
  a_err_long: assert property (p_err_long) else $error("check flag set in short frame mode");
  property p_so_hold;
    @(posedge sclk) disable iff (frame_sync_n) fell_q |-> serial_out == so_q;
  endproperty
  a_so_hold: assert property (p_so_hold) else $error("serial output changed before clock rise");
  c_load: cover property (@(posedge ref_clk) $fell(load_outputs_n) && !clear);
  c_clear: cover property (@(posedge ref_clk) $rose(clear));
  c_err: cover property (@(posedge ref_clk) $rose(check_error));
endmodule : port_checks

// ---- verification/serial_host.sv ----
`timescale 1ns/1ps
module serial_host
(
  // Link pins
  output logic sclk,
  output logic frame_sync_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial
  begin
    sclk = 1'b1;
    frame_sync_n = 1'b0;
    serial_in = 1'b0;
    // Link flops have no reset; one select rise presets the frame-start flops
    #1;
    frame_sync_n = 1'b1;
  end
  // ---
  // Frame: clock stands high between frames, released data inverts
  // ---
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = '0;
    #3.7;
    frame_sync_n = 1'b0;
    #7;
    for (int i = 0; i < n; i++)
    begin
      serial_in = w[31-i];
      #6;
      sclk = 1'b0;
      r = {r[30:0], serial_out};
      #6;
      sclk = 1'b1;
    end
    #13;
    frame_sync_n = 1'b1;
    serial_in = ~serial_in;
    #400;
  endtask : xfer
endmodule : serial_host

// ---- verification/tb_dac_serial_load_clear_port.sv ----
`timescale 1ns/1ps
`include "dac_port_consts.svh"
bind dac_serial_load_clear_port port_checks #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .sclk(sclk), .frame_sync_n(frame_sync_n), .serial_in(serial_in), .serial_out(serial_out),
  .load_outputs_n(load_outputs_n), .clear(clear), .reset_n(reset_n), .long_frame_en(long_frame_en),
  .board_addr_bit0(board_addr_bit0), .board_addr_bit1(board_addr_bit1), .dac_codes(dac_codes),
  .check_error(check_error));
module tb_dac_serial_load_clear_port
  import dac_port_pkg::*;
;
  logic ref_clk, sys_rst, sclk, frame_sync_n, serial_in, serial_out, check_error;
  logic load_outputs_n, clear, reset_n, long_frame_en, board_addr_bit0, board_addr_bit1;
  logic [3:0][15:0] dac_codes;
  code_t in_m [4], out_m [4], cc_m [4];
  logic [15:0] en_m [4];
  logic [31:0] rnd, rd;
  logic [1:0] a;
  int errors, n_compared;
  serial_host host (.sclk(sclk), .frame_sync_n(frame_sync_n), .serial_in(serial_in), .serial_out(serial_out));
  dac_serial_load_clear_port #(.CHANNELS(4), .CODE_W(16)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk),
    .frame_sync_n(frame_sync_n), .serial_in(serial_in), .serial_out(serial_out), .load_outputs_n(load_outputs_n),
    .clear(clear), .reset_n(reset_n), .long_frame_en(long_frame_en), .board_addr_bit0(board_addr_bit0),
    .board_addr_bit1(board_addr_bit1), .dac_codes(dac_codes), .check_error(check_error));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] crc8(input payload_t p);
    logic [7:0] c;
    c = `CHECK_SEED;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? `CHECK_POLY : 8'h00);
    return c;
  endfunction : crc8
  function automatic code_t rbv(input int s);
    return (s == 0) ? in_m[2] : (s == 1) ? out_m[2] : (s == 2) ? cc_m[2] : en_m[2];
  endfunction : rbv
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cmp_codes();
    for (int c = 0; c < 4; c++)
      cmp("dac_codes", {8'h0, out_m[c]}, {8'h0, dac_codes[c]});
  endtask : cmp_codes
  task automatic send(input logic [2:0] cmd, input logic [1:0] ch, input code_t d, input logic [1:0] ad, input int n,
    input logic bad);
    payload_t p;
    p = {1'b0, ad, ch, cmd, d};
    host.xfer({p, crc8(p) ^ {7'h0, bad}}, n, rd);
    repeat (10) @(negedge ref_clk);
  endtask : send
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    #2ms;
    errors++;
    print_verdict();
  end
  initial
  begin
    errors = 0;
    n_compared = 0;
    rnd = 32'h91e2;
    {sys_rst, load_outputs_n, clear, reset_n, long_frame_en, board_addr_bit1, board_addr_bit0} = 7'h48;
    in_m = '{default: 16'h0};
    out_m = '{default: 16'h0};
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    cmp_codes();
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      {board_addr_bit1, board_addr_bit0} = rnd[17:16];
      repeat (8) @(negedge ref_clk);
      send(`CMD_WRITE_DATA, rnd[19:18], rnd[15:0], rnd[17:16] ^ {1'b0, k[0]}, 24, 1'b0);
      if (!k[0])
      begin
        in_m[rnd[19:18]] = rnd[15:0];
        out_m[rnd[19:18]] = rnd[15:0];
      end
      cmp_codes();
    end
    a = rnd[17:16];
    for (int n = 23; n <= 25; n += 2)
    begin
      send(`CMD_WRITE_DATA, 2'h0, 16'hbeef, a, n, 1'b0);
      cmp_codes();
    end
    load_outputs_n = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      rnd = lfsr(rnd);
      send(`CMD_WRITE_DATA, 2'(c), rnd[15:0], a, 24, 1'b0);
      in_m[c] = rnd[15:0];
      send(`CMD_WRITE_CLEAR_CODE, 2'(c), rnd[31:16], a, 24, 1'b0);
      cc_m[c] = rnd[31:16];
      en_m[c] = {15'h0, !c[0]};
      send(`CMD_WRITE_CLEAR_EN, 2'(c), en_m[c], a, 24, 1'b0);
    end
    cmp_codes();
    load_outputs_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    out_m = in_m;
    cmp_codes();
    clear = 1'b1;
    repeat (10) @(negedge ref_clk);
    for (int c = 0; c < 4; c++)
      out_m[c] = en_m[c][0] ? cc_m[c] : out_m[c];
    cmp_codes();
    send(`CMD_WRITE_DATA, 2'h1, 16'h5a5a, a, 24, 1'b0);
    in_m[1] = 16'h5a5a;
    cmp_codes();
    for (int s = 0; s < 5; s++)
    begin
      send((s < 4) ? `CMD_READBACK : `CMD_NOP, 2'h2, 16'(s), a, 24, 1'b0);
      if (s > 0)
        cmp("readback", {4'h0, 2'h2, 2'(s - 1), rbv(s - 1)}, rd[23:0]);
    end
    clear = 1'b0;
    load_outputs_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    load_outputs_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    out_m = in_m;
    cmp_codes();
    long_frame_en = 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      rnd = lfsr(rnd);
      send(`CMD_WRITE_DATA, 2'h3, rnd[15:0], a, 32, b[0]);
      out_m[3] = b[0] ? out_m[3] : rnd[15:0];
      cmp_codes();
      cmp("check_error", {23'h0, b[0]}, {23'h0, check_error});
    end
    reset_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    out_m = '{default: 16'h0};
    cmp_codes();
    cmp("check_error", 24'h0, {23'h0, check_error});
    print_verdict();
  end
endmodule : tb_dac_serial_load_clear_port
